// File: indexed_stack_instructions_tb_top.sv
/* random self-checking bench for the decoder.
   bench drives pointers, memory read data and ce; a write queue holds the predicted writes. */
`timescale 1ns/1ps
module indexed_stack_instructions_tb_top;
   logic clk = 0, nrst = 0, ce = 1, ext_en = 1, iv = 0;
   logic [15:0] insn = 16'h0000;
   logic [11:0] p0 = 12'h000, p1 = 12'h000, sp = 12'h000, m_ad, pv;
   logic [7:0] rd = 8'h00, k, wd;
   logic [6:0] zs, zd;
   logic m_rd, m_we, pl, bsy, bad;
   logic [1:0] ps;
   int mismatches = 0, cmp_count = 0, seed = 85, cyc = 0, i, d, e;
   int wq[$];
   always #5 clk = ~clk;
   isi_decoder DUT (.clk(clk), .nrst(nrst), .ce(ce), .ext_en(ext_en), .insn_valid(iv),
      .insn(insn), .ptr0(p0), .ptr1(p1), .software_stack_pointer(sp), .mem_rdata(rd),
      .mem_rd(m_rd), .mem_we(m_we), .mem_addr(m_ad), .mem_wdata(wd), .ptr_load(pl),
      .ptr_sel(ps), .ptr_value(pv), .busy(bsy), .bad_opcode(bad));
   task automatic chk(logic [31:0] got, logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      $display("mismatches=%0d cmp_count=%0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // iv stays up so words can follow back to back
   task automatic issue(logic [15:0] w);
      insn = w;
      iv = 1;
      @(negedge clk);
   endtask
   function automatic bit nowr(int a);
      return a inside {[12'hFDF:12'hFE3], [12'hFE7:12'hFEB], [12'hFEF:12'hFF3],
         12'hFF9, [12'hFFD:12'hFFF]};
   endfunction
   // every write must be one the model predicted, in order
   always @(negedge clk) begin
      if (nrst && m_we) begin
         chk(wq.size() != 0, 1);
         if (wq.size() != 0) chk({m_ad, wd}, wq.pop_front());
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc > 2000) begin
         mismatches++;
         test_done;
      end
   end
   initial begin
      repeat (20) @(negedge clk);
      chk({m_rd, m_we, pl, bsy, bad}, 16'h0000);
      nrst = 1;
      @(negedge clk);
      for (i = 0; i < 40; i++) begin
         sp = i == 0 ? 12'h000 : 12'($random(seed));
         k = 8'($random(seed));
         wq.push_back({sp, k});
         issue({8'hFA, k});
         chk(m_we, 1);
         chk({m_ad, wd}, {sp, k});
         chk({pl, ps}, 3'h6);
         chk(pv, (sp + 4095) % 4096);
      end
      // a word presented while ce is low must wait for ce
      iv = 0;
      @(negedge clk);
      ce = 0;
      sp = 12'($random(seed));
      issue({8'hFA, 8'h5A});
      chk({m_we, pl, bsy}, 0);
      ce = 1;
      wq.push_back({sp, 8'h5A});
      @(negedge clk);
      chk(pv, (sp + 4095) % 4096);
      for (i = 0; i < 40; i++) begin
         ext_en = i % 7 != 6;
         p0 = 12'($random(seed));
         p1 = 12'($random(seed));
         sp = 12'($random(seed));
         k = i == 1 ? 8'h3F : 8'($random(seed));
         e = i % 4 == 0 ? p0 : i % 4 == 1 ? p1 : sp;
         issue({8'hE9, 2'(i), k[5:0]});
         chk(pl, ext_en && i % 4 != 3);
         if (pl) begin
            chk(ps, i % 4);
            chk(pv, (e + 4096 - k[5:0]) % 4096);
         end
      end
      ext_en = 1;
      for (i = 0; i < 30; i++) begin
         sp = i == 0 ? 12'hFFF : i == 1 ? 12'hFE0 : i == 2 ? 12'hFF0 : 12'($random(seed));
         zs = 7'($random(seed));
         zd = i == 1 ? 7'h00 : i == 2 ? 7'h09 : 7'($random(seed));
         rd = 8'($random(seed));
         d = (sp + zd) % 4096;
         issue({9'h1D7, zs});
         chk({m_rd, bsy, m_ad}, {2'h3, 12'((sp + zs) % 4096)});
         if (!nowr(d)) wq.push_back({d[11:0], rd});
         issue({9'h1E0, zd});
         chk(m_we, !nowr(d));
         chk(bad, d == 12'hFF9 || d >= 12'hFFD);
         if (!nowr(d)) chk({m_ad, wd}, {d[11:0], rd});
         iv = 0;
         do @(negedge clk); while (bsy);
      end
      chk(wq.size(), 0);
      test_done;
   end
endmodule

// File: isi_addr_calc.sv
/*
 * isi_addr_calc: indexed address adder with destination classification.
 * assumes purely combinational use by the decoder on the same clock.
 */
`timescale 1ns/1ps
module isi_addr_calc (
   isi_mem_if.calc m
);
   logic [isi_pkg::ADDR_W-1:0] s;
   always_comb begin
      // carry past bit 11 drops on purpose
      s = m.base + {{(isi_pkg::ADDR_W-isi_pkg::OFFS_W){1'b0}}, m.offs};
      m.sum = s;
      m.indirect = ((s >= isi_pkg::ADR_IND2) && (s < isi_pkg::ADR_IND2 + 12'(isi_pkg::IND_SPAN)))
         || ((s >= isi_pkg::ADR_IND1) && (s < isi_pkg::ADR_IND1 + 12'(isi_pkg::IND_SPAN)))
         || ((s >= isi_pkg::ADR_IND0) && (s < isi_pkg::ADR_IND0 + 12'(isi_pkg::IND_SPAN)));
      m.protected_dst = (s == isi_pkg::ADR_PC_LOW) || (s == isi_pkg::ADR_STACK_TOP_LOW)
         || (s == isi_pkg::ADR_STACK_TOP_HIGH) || (s == isi_pkg::ADR_STACK_TOP_UPPER);
   end
endmodule

// File: isi_decoder.sv
/*
 * isi_decoder: executes indexed move, push literal and subtract-from-pointer.
 * assumes the core presents one instruction word per valid strobe, with data
 * memory answering reads one cycle later, and owns the pointers via load ports.
 */
// Functional notes
// - move addresses are stack pointer plus 7-bit offsets, first word 1110 1011 1.
// - move is two words, three cycles: read source, write destination, then one settling cycle.
// - move must never write program counter low or stack top bytes.
// - move whose destination is an indirect register writes nothing.
// - push literal is one word 1111 1010 kkkk kkkk, one cycle.
// - push literal writes literal at current stack pointer address.
// - push literal then decrements the stack pointer by one.
// - subtract-from-pointer is 1110 1001 ffkk kkkk, selects pointer 0-2, one cycle.
// - subtract 6-bit literal from chosen pointer, no status flag change.
// - all three decode a first word only while the extended set is enabled; a move's second word is taken whatever ext_en is.
`timescale 1ns/1ps
module isi_decoder (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic ext_en,
   input wire logic insn_valid,
   input wire logic [isi_pkg::INSN_W-1:0] insn,
   input wire logic [isi_pkg::ADDR_W-1:0] ptr0,
   input wire logic [isi_pkg::ADDR_W-1:0] ptr1,
   input wire logic [isi_pkg::ADDR_W-1:0] software_stack_pointer,
   input wire logic [7:0] mem_rdata,
   output logic mem_rd,
   output logic mem_we,
   output logic [isi_pkg::ADDR_W-1:0] mem_addr,
   output logic [7:0] mem_wdata,
   output logic ptr_load,
   output logic [1:0] ptr_sel,
   output logic [isi_pkg::ADDR_W-1:0] ptr_value,
   output logic busy,
   output logic bad_opcode
);
   typedef enum logic [2:0] {
      ISI_IDLE = 3'b001,
      ISI_MOVE2 = 3'b010,
      ISI_FILL = 3'b100
   } isi_state_e;

   isi_mem_if am ();
   isi_addr_calc u_calc (
      .m(am)
   );

   // the opcode slices below are fixed to this word and field layout
   if (isi_pkg::INSN_W != 16) begin : g_chk_insn_w
      $error("isi_decoder: opcode slices need a 16-bit instruction word");
   end
   if (isi_pkg::ADDR_W != 12) begin : g_chk_addr_w
      $error("isi_decoder: special destinations assume a 12-bit data space");
   end
   if ((isi_pkg::OFFS_W != 7) || (isi_pkg::SUBK_W != 6)) begin : g_chk_fields
      $error("isi_decoder: offset and literal fields must be 7 and 6 bits");
   end

   isi_state_e state_ff, nxt_state;
   logic busy_ff, nxt_busy;
   logic bad_ff, nxt_bad;
   logic mem_rd_ff, nxt_mem_rd;
   logic mem_we_ff, nxt_mem_we;
   logic [isi_pkg::ADDR_W-1:0] mem_addr_ff, nxt_mem_addr;
   logic [7:0] mem_wdata_ff, nxt_mem_wdata;
   logic ptr_load_ff, nxt_ptr_load;
   logic [1:0] ptr_sel_ff, nxt_ptr_sel;
   logic [isi_pkg::ADDR_W-1:0] ptr_value_ff, nxt_ptr_value;

   logic is_move, is_push, is_sub, is_second;
   logic take_move, take_push, take_sub, take_dest, dst_write;
   logic [isi_pkg::ADDR_W-1:0] sel_ptr;

   // adder inputs kept apart so the decode below reads only settled results
   always_comb begin
      am.base = software_stack_pointer;
      am.offs = insn[isi_pkg::OFFS_W-1:0];
   end

   // decode; only the idle state accepts a first word
   always_comb begin
      is_move = ext_en && (insn[15:7] == isi_pkg::OP_MOVE_W1);
      is_push = ext_en && (insn[15:8] == isi_pkg::OP_PUSH_LIT);
      // select 3 is the neighbouring return form, not handled here
      is_sub = ext_en && (insn[15:8] == isi_pkg::OP_SUB_PTR)
         && (insn[7:6] != isi_pkg::SEL_NONE);
      is_second = (insn[15:12] == isi_pkg::OP_SECOND);
      case (insn[7:6])
         2'h0: sel_ptr = ptr0;
         2'h1: sel_ptr = ptr1;
         default: sel_ptr = software_stack_pointer;
      endcase
      take_move = insn_valid && (state_ff == ISI_IDLE) && is_move;
      take_push = insn_valid && (state_ff == ISI_IDLE) && is_push;
      take_sub = insn_valid && (state_ff == ISI_IDLE) && is_sub;
      take_dest = insn_valid && (state_ff == ISI_MOVE2);
      // a blocked destination turns the move into a no-op
      dst_write = is_second && !am.indirect && !am.protected_dst;
   end

   // sequencer: source cycle, destination cycle, one settling cycle
   always_comb begin
      nxt_state = state_ff;
      nxt_bad = 1'b0;
      case (state_ff)
         ISI_IDLE: begin
            if (take_move) begin
               nxt_state = ISI_MOVE2;
            end
         end
         ISI_MOVE2: begin
            if (take_dest) begin
               nxt_state = ISI_FILL;
               // malformed second word or protected target is reported
               nxt_bad = !is_second || am.protected_dst;
            end
         end
         ISI_FILL: begin
            nxt_state = ISI_IDLE;
         end
         default: begin
            nxt_state = ISI_IDLE;
         end
      endcase
      // busy is registered so the pin leaves a flop, not a decode
      nxt_busy = (nxt_state != ISI_IDLE);
   end

   // frozen with the rest of the unit while ce is low
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_ff <= ISI_IDLE;
         busy_ff <= 1'b0;
         bad_ff <= 1'b0;
      end else if (ce) begin
         state_ff <= nxt_state;
         busy_ff <= nxt_busy;
         bad_ff <= nxt_bad;
      end
   end

   // data-memory port; strobes last one cycle, address and data hold
   always_comb begin
      nxt_mem_rd = 1'b0;
      nxt_mem_we = 1'b0;
      nxt_mem_addr = mem_addr_ff;
      nxt_mem_wdata = mem_wdata_ff;
      if (take_move) begin
         // cycle one: read the source
         nxt_mem_rd = 1'b1;
         nxt_mem_addr = am.sum;
      end else if (take_push) begin
         nxt_mem_we = 1'b1;
         nxt_mem_addr = software_stack_pointer;
         nxt_mem_wdata = insn[7:0];
      end else if (take_dest) begin
         // cycle two: source byte is on mem_rdata, word two gives the target
         nxt_mem_we = dst_write;
         nxt_mem_addr = am.sum;
         nxt_mem_wdata = mem_rdata;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mem_rd_ff <= 1'b0;
         mem_we_ff <= 1'b0;
         mem_addr_ff <= isi_pkg::RST_PTR;
         mem_wdata_ff <= isi_pkg::RST_BYTE;
      end else if (ce) begin
         mem_rd_ff <= nxt_mem_rd;
         mem_we_ff <= nxt_mem_we;
         mem_addr_ff <= nxt_mem_addr;
         mem_wdata_ff <= nxt_mem_wdata;
      end
   end

   // pointer port; the core owns the pointers and loads the value
   always_comb begin
      nxt_ptr_load = 1'b0;
      nxt_ptr_sel = ptr_sel_ff;
      nxt_ptr_value = ptr_value_ff;
      if (take_push) begin
         nxt_ptr_load = 1'b1;
         nxt_ptr_sel = 2'h2;
         // post-decrement: the stack grows toward lower addresses
         nxt_ptr_value = software_stack_pointer - 12'h001;
      end else if (take_sub) begin
         // pointer only; status flags are never touched
         nxt_ptr_load = 1'b1;
         nxt_ptr_sel = insn[7:6];
         nxt_ptr_value = sel_ptr - {6'h00, insn[isi_pkg::SUBK_W-1:0]};
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ptr_load_ff <= 1'b0;
         ptr_sel_ff <= 2'h0;
         ptr_value_ff <= isi_pkg::RST_PTR;
      end else if (ce) begin
         ptr_load_ff <= nxt_ptr_load;
         ptr_sel_ff <= nxt_ptr_sel;
         ptr_value_ff <= nxt_ptr_value;
      end
   end

   // every pin is a plain copy of its register
   assign mem_rd = mem_rd_ff;
   assign mem_we = mem_we_ff;
   assign mem_addr = mem_addr_ff;
   assign mem_wdata = mem_wdata_ff;
   assign ptr_load = ptr_load_ff;
   assign ptr_sel = ptr_sel_ff;
   assign ptr_value = ptr_value_ff;
   assign busy = busy_ff;
   assign bad_opcode = bad_ff;
endmodule

// File: isi_decoder_sva.sv
/* isi_decoder_sva: port checker for the decoder.
   bound onto isi_decoder; one clock, async low reset. */
`timescale 1ns/1ps
module isi_chk (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic ext_en,
   input wire logic insn_valid,
   input wire logic [15:0] insn,
   input wire logic [11:0] ptr0,
   input wire logic [11:0] software_stack_pointer,
   input wire logic [7:0] mem_rdata,
   input wire logic mem_rd,
   input wire logic mem_we,
   input wire logic [11:0] mem_addr,
   input wire logic [7:0] mem_wdata,
   input wire logic ptr_load,
   input wire logic [1:0] ptr_sel,
   input wire logic [11:0] ptr_value,
   input wire logic busy
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   wire tk = ce && insn_valid && ext_en && !busy;
   wire [7:0] op = insn[15:8];
   wire [11:0] sp = software_stack_pointer;
   property p_psh; tk && op == 8'hFA |=>
      mem_we && mem_addr == $past(sp) && mem_wdata == $past(insn[7:0]); endproperty
   a_psh: assert property (p_psh) else $error("push write wrong");
   property p_dec; tk && op == 8'hFA |=>
      ptr_load && ptr_sel == 2'h2 && ptr_value == $past(sp) - 12'h001; endproperty
   a_dec: assert property (p_dec) else $error("push pointer wrong");
   property p_sub; tk && op == 8'hE9 && insn[7:6] == 2'h0 |=> ptr_load &&
      ptr_sel == 2'h0 && ptr_value == $past(ptr0) - $past(insn[5:0]); endproperty
   a_sub: assert property (p_sub) else $error("subtract wrong");
   property p_sf3; tk && op == 8'hE9 && insn[7:6] == 2'h3 |=> !ptr_load; endproperty
   a_sf3: assert property (p_sf3) else $error("select 3 acted");
   property p_off; ce && !ext_en && !busy |=> !mem_we && !ptr_load && !mem_rd; endproperty
   a_off: assert property (p_off) else $error("acted while disabled");
   property p_rd; tk && insn[15:7] == 9'h1D7 |=>
      mem_rd && busy && mem_addr == $past(sp) + $past(insn[6:0]); endproperty
   a_rd: assert property (p_rd) else $error("move read wrong");
   property p_mv; mem_we && $past(busy) |-> mem_wdata == $past(mem_rdata); endproperty
   a_mv: assert property (p_mv) else $error("move data wrong");
   property p_prt; mem_we && $past(busy) |->
      mem_addr != 12'hFF9 && mem_addr < 12'hFFD; endproperty
   a_prt: assert property (p_prt) else $error("protected write");
endmodule
bind isi_decoder isi_chk u_chk (.*);

// File: isi_mem_if.sv
/*
 * isi_mem_if: data-memory access bundle used inside the unit.
 * assumes the decoder drives base and offs and reads the rest combinationally.
 */
`timescale 1ns/1ps
interface isi_mem_if;
   logic [isi_pkg::OFFS_W-1:0] offs;
   logic [isi_pkg::ADDR_W-1:0] base;
   logic [isi_pkg::ADDR_W-1:0] sum;
   logic indirect;
   logic protected_dst;
   modport user (output base, output offs, input sum, input indirect, input protected_dst);
   modport calc (input base, input offs, output sum, output indirect, output protected_dst);
endinterface

// File: isi_pkg.sv
/*
 * isi_pkg: constants for the indexed/stack instruction unit.
 * assumes a 16-bit instruction word and a 12-bit data address space.
 */
package isi_pkg;
   localparam int ADDR_W = 12;
   localparam int INSN_W = 16;
   localparam int OFFS_W = 7;
   localparam int SUBK_W = 6;
   // opcode fields
   localparam logic [8:0] OP_MOVE_W1 = 9'h1D7;   // 1110 1011 1
   localparam logic [3:0] OP_SECOND = 4'hF;      // second word prefix
   localparam logic [7:0] OP_PUSH_LIT = 8'hFA;   // 1111 1010
   localparam logic [7:0] OP_SUB_PTR = 8'hE9;    // 1110 1001
   localparam logic [1:0] SEL_NONE = 2'h3;
   // special destinations
   localparam logic [11:0] ADR_PC_LOW = 12'hFF9;
   localparam logic [11:0] ADR_STACK_TOP_LOW = 12'hFFD;
   localparam logic [11:0] ADR_STACK_TOP_HIGH = 12'hFFE;
   localparam logic [11:0] ADR_STACK_TOP_UPPER = 12'hFFF;
   // indirect access windows, one per pointer
   localparam logic [11:0] ADR_IND0 = 12'hFEF;
   localparam logic [11:0] ADR_IND1 = 12'hFE7;
   localparam logic [11:0] ADR_IND2 = 12'hFDF;
   localparam logic [2:0] IND_SPAN = 3'h5;       // registers in each window
   localparam logic [11:0] RST_PTR = 12'h000;
   localparam logic [7:0] RST_BYTE = 8'h00;
endpackage
